/* verilog/rpim_pkg.sv */
package rpim_pkg;
    localparam logic [7:0] PORT_SELECT_OFS = 8'h4c;
    localparam logic [7:0] LINK_CFG_CTRL_OFS = 8'h59;
    localparam logic [7:0] LINK_CFG_SPARE_OFS = 8'h5a;
    localparam logic [7:0] SER_ADDR_OFS = 8'h5b;
    localparam logic [7:0] SER_ALIAS_OFS = 8'h5c;
    localparam logic [7:0] TARGET0_OFS = 8'h5d;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int OVERRIDE_BIT = 7;
    localparam int HOLD_BIT = 0;
    localparam int AUTO_ACK_BIT = 0;
    localparam int PASS_THROUGH_BIT = 6;
    localparam logic [7:0] LINK_CFG_WMASK = 8'hff;
    localparam logic [7:0] TARGET_WMASK = 8'hfe;
    localparam logic [6:0] ALIAS_OFF = 7'h00;
    localparam logic [1:0] GPIO_NONE = 2'h0;
    localparam logic [1:0] GPIO_ONE = 2'h1;
    localparam logic [1:0] GPIO_TWO = 2'h2;
    localparam logic [1:0] GPIO_FOUR = 2'h3;
endpackage

/* verilog/rpim_regs.sv */
// How it works
// - One register copy per port; port-select chooses which copy I2C accesses.
// - Override bit 7 set blocks forward-channel link-config loads and keeps local values.
// - Override clear lets forward-channel data load link config; reset clear.
// - Forward GPIO count: 0 none, 1 one, 2 two, 3 four; resets zero.
// - GPIO count loads from serializer; software writes it only when override is 1.
// - Seven-bit serializer address in bits 7:1 autoloads over the link.
// - Hold bit 0 stops serializer address updates, keeping the written value.
// - Local I2C address is compared to alias field bits 7:1.
// - On alias match the address is replaced by the target register address.
// - Alias field zero disables remote access through this alias.
// - Auto-ack bit 0 acknowledges all writes to the remote serializer.
// - Target register bits 7:1 hold the remote physical address; bit 0 reads zero.
// - Transactions to the first target alias are rewritten before crossing the channel.
// - Matching transactions forward only when pass-through enable bit 6 is set.
module rpim_regs #(
    parameter int NPORTS = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register access from the local I2C controller.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Forward-channel configuration loads, one per port.
    input wire logic [NPORTS-1:0] fc_load,
    input wire logic [NPORTS*8-1:0] fc_link_cfg,
    input wire logic [NPORTS*7-1:0] fc_ser_addr,
    // Per-port pass-through enables from the back-channel configuration.
    input wire logic [NPORTS-1:0] pass_through_en,
    // Local I2C transaction decode.
    input wire logic txn_valid,
    input wire logic [6:0] txn_addr,
    input wire logic txn_write,
    output logic fwd_valid,
    output logic [$clog2(NPORTS+1)-1:0] fwd_port,
    output logic [6:0] fwd_addr,
    output logic fwd_auto_ack,
    // Per-port forward GPIO count, decoded to a number of GPIOs.
    output logic [NPORTS*3-1:0] gpio_enabled
);
    localparam int PW = $clog2(NPORTS+1);

    logic [7:0] port_select;
    logic [7:0] link_cfg [NPORTS];
    logic [7:0] link_spare [NPORTS];
    logic [7:0] ser_addr [NPORTS];
    logic [7:0] ser_alias [NPORTS];
    logic [7:0] target0 [NPORTS];
    logic [2:0] gpio_q [NPORTS];

    wire sel_wr_port = reg_wr && reg_addr == rpim_pkg::PORT_SELECT_OFS;
    wire [PW-1:0] cur_port = PW'(port_select[3:0]);
    // The full low nibble is range-checked, so a high nibble code cannot alias onto a real port; bits 7:4 are ignored.
    wire port_ok = 32'(port_select[3:0]) < NPORTS;

    logic [NPORTS-1:0] match;
    logic [7:0] port_rdata [NPORTS];
    logic [NPORTS*PW-1:0] idx_chain;
    logic [NPORTS*7-1:0] addr_chain;
    logic [NPORTS-1:0] ack_chain;

    genvar g;
    generate
        for (g = 0; g < NPORTS; g++) begin : g_port
            wire sel = port_ok && cur_port == PW'(g);
            wire wr_cfg = reg_wr && sel && reg_addr == rpim_pkg::LINK_CFG_CTRL_OFS;
            wire wr_spare = reg_wr && sel && reg_addr == rpim_pkg::LINK_CFG_SPARE_OFS;
            wire wr_ser = reg_wr && sel && reg_addr == rpim_pkg::SER_ADDR_OFS;
            wire wr_alias = reg_wr && sel && reg_addr == rpim_pkg::SER_ALIAS_OFS;
            wire wr_tgt = reg_wr && sel && reg_addr == rpim_pkg::TARGET0_OFS;
            wire override = link_cfg[g][rpim_pkg::OVERRIDE_BIT];
            wire hold = ser_addr[g][rpim_pkg::HOLD_BIT];
            // Override bit itself is always writable; the GPIO field only while overriding.
            wire [1:0] next_gpio = (wr_cfg && override) ? reg_wdata[1:0]
                : (fc_load[g] && !override) ? fc_link_cfg[g*8 +: 2] : link_cfg[g][1:0];
            wire [4:0] next_rsvd = wr_cfg ? reg_wdata[6:2]
                : (fc_load[g] && !override) ? fc_link_cfg[g*8+2 +: 5] : link_cfg[g][6:2];
            wire next_ovr = wr_cfg ? reg_wdata[7] : override;
            wire [6:0] next_id = wr_ser ? reg_wdata[7:1]
                : (fc_load[g] && !hold) ? fc_ser_addr[g*7 +: 7] : ser_addr[g][7:1];
            wire next_hold = wr_ser ? reg_wdata[0] : hold;
            // A code of three means four lines, not three.
            wire [2:0] next_gpio_num = next_gpio == rpim_pkg::GPIO_FOUR ? 3'h4 : {1'b0, next_gpio};

            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    link_cfg[g] <= rpim_pkg::REG_RESET;
                    link_spare[g] <= rpim_pkg::REG_RESET;
                    ser_addr[g] <= rpim_pkg::REG_RESET;
                    gpio_q[g] <= 3'(rpim_pkg::GPIO_NONE);
                    ser_alias[g] <= rpim_pkg::REG_RESET;
                    target0[g] <= rpim_pkg::REG_RESET;
                end else begin
                    link_cfg[g] <= {next_ovr, next_rsvd, next_gpio};
                    ser_addr[g] <= {next_id, next_hold};
                    gpio_q[g] <= next_gpio_num;
                    if (wr_spare) begin
                        link_spare[g] <= reg_wdata;
                    end
                    if (wr_alias) begin
                        ser_alias[g] <= reg_wdata;
                    end
                    if (wr_tgt) begin
                        target0[g] <= reg_wdata & rpim_pkg::TARGET_WMASK;
                    end
                end
            end

            wire [6:0] alias_id = ser_alias[g][7:1];
            assign match[g] = alias_id != rpim_pkg::ALIAS_OFF && alias_id == txn_addr
                && pass_through_en[g];
            assign port_rdata[g] =
                reg_addr == rpim_pkg::LINK_CFG_CTRL_OFS ? link_cfg[g] :
                reg_addr == rpim_pkg::LINK_CFG_SPARE_OFS ? link_spare[g] :
                reg_addr == rpim_pkg::SER_ADDR_OFS ? ser_addr[g] :
                reg_addr == rpim_pkg::SER_ALIAS_OFS ? ser_alias[g] :
                reg_addr == rpim_pkg::TARGET0_OFS ? target0[g] : 8'h00;
            // The decoded count sits in a flop so the output never glitches while the field loads.
            assign gpio_enabled[g*3 +: 3] = gpio_q[g];
            // Lowest port wins when two aliases collide; software should keep aliases unique.
            if (g == 0) begin : g_first
                assign idx_chain[PW-1:0] = match[0] ? PW'(0) : PW'(NPORTS);
                assign addr_chain[6:0] = target0[0][7:1];
                assign ack_chain[0] = ser_alias[0][rpim_pkg::AUTO_ACK_BIT];
            end else begin : g_next
                wire take = match[g] && !(|match[g-1:0]);
                assign idx_chain[g*PW +: PW] = take ? PW'(g) : idx_chain[(g-1)*PW +: PW];
                assign addr_chain[g*7 +: 7] = take ? target0[g][7:1] : addr_chain[(g-1)*7 +: 7];
                assign ack_chain[g] = take ? ser_alias[g][rpim_pkg::AUTO_ACK_BIT] : ack_chain[g-1];
            end
        end
    endgenerate

    wire any_match = |match;
    wire [7:0] next_rdata = reg_addr == rpim_pkg::PORT_SELECT_OFS ? port_select
        : port_ok ? port_rdata[cur_port[$clog2(NPORTS)-1:0]] : 8'h00;

    // When nothing matches, fwd_port shows NPORTS, a code that names no port.

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_select <= rpim_pkg::REG_RESET;
            reg_rdata <= rpim_pkg::REG_RESET;
            fwd_valid <= 1'b0;
            fwd_port <= '0;
            fwd_addr <= '0;
            fwd_auto_ack <= 1'b0;
        end else begin
            if (sel_wr_port) begin
                port_select <= reg_wdata;
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
            fwd_valid <= txn_valid && any_match;
            fwd_port <= idx_chain[(NPORTS-1)*PW +: PW];
            fwd_addr <= addr_chain[(NPORTS-1)*7 +: 7];
            fwd_auto_ack <= txn_valid && any_match && txn_write && ack_chain[NPORTS-1];
        end
    end

    AST_FWD_ONLY_ON_MATCH: assert property (@(posedge clk) disable iff (!nrst)
        fwd_valid |-> $past(txn_valid) && $past(any_match))
        else $error("Forward without alias match.");
    AST_ALIAS_ZERO_OFF: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && !any_match) |=> !fwd_valid)
        else $error("Forward with alias disabled.");
    AST_PASS_GATE: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && pass_through_en == '0) |=> !fwd_valid)
        else $error("Forward without pass-through.");
    AST_REMAP0: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && match[0]) |=> fwd_addr == $past(target0[0][7:1]) && fwd_port == '0)
        else $error("Port zero remap wrong.");
    AST_TGT_BIT0: assert property (@(posedge clk) disable iff (!nrst)
        target0[0][0] == 1'b0)
        else $error("Target bit 0 not zero.");
    AST_OVERRIDE_KEEPS: assert property (@(posedge clk) disable iff (!nrst)
        (link_cfg[0][7] && !(reg_wr && cur_port == '0)) |=> $stable(link_cfg[0]))
        else $error("Override did not hold config.");
    AST_FC_LOAD: assert property (@(posedge clk) disable iff (!nrst)
        (fc_load[0] && !link_cfg[0][7] && !reg_wr) |=> link_cfg[0][1:0] == $past(fc_link_cfg[1:0]))
        else $error("Forward load missed.");
    AST_GPIO_LOCKED: assert property (@(posedge clk) disable iff (!nrst)
        (!link_cfg[0][7] && !fc_load[0]) |=> link_cfg[0][1:0] == $past(link_cfg[0][1:0]))
        else $error("GPIO count written without override.");
    AST_HOLD_ID: assert property (@(posedge clk) disable iff (!nrst)
        (ser_addr[0][0] && !(reg_wr && cur_port == '0)) |=> $stable(ser_addr[0]))
        else $error("Held address changed.");
    AST_GPIO_DECODE: assert property (@(posedge clk) disable iff (!nrst)
        link_cfg[0][1:0] == rpim_pkg::GPIO_FOUR |-> gpio_enabled[2:0] == 3'h4)
        else $error("GPIO decode wrong.");
    AST_AUTO_ACK: assert property (@(posedge clk) disable iff (!nrst)
        fwd_auto_ack |-> fwd_valid)
        else $error("Auto-ack without forward.");
    AST_PORT_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        (reg_wr && !port_ok) |=> $stable(ser_alias[0]) && $stable(target0[0]))
        else $error("Write reached a port that was not selected.");
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("Read data changed without a read.");
    AST_ACK_WRITE_ONLY: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && !txn_write) |=> !fwd_auto_ack)
        else $error("Auto-ack on a read.");
    AST_ACK_ON_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && txn_write && match[0] && ser_alias[0][rpim_pkg::AUTO_ACK_BIT]) |=> fwd_auto_ack)
        else $error("Auto-ack missing on a write.");
    AST_GPIO_DECODE_LOW: assert property (@(posedge clk) disable iff (!nrst)
        link_cfg[0][1:0] != rpim_pkg::GPIO_FOUR |-> gpio_enabled[2:0] == {1'b0, link_cfg[0][1:0]})
        else $error("GPIO low decode wrong.");
    AST_FWD_PORT_IDLE: assert property (@(posedge clk) disable iff (!nrst)
        (txn_valid && !any_match) |=> fwd_port == PW'(NPORTS))
        else $error("Port index shown without a match.");

    COV_FWD: cover property (@(posedge clk) disable iff (!nrst) fwd_valid);
    COV_ACK: cover property (@(posedge clk) disable iff (!nrst) fwd_auto_ack);
    COV_FC_LOAD: cover property (@(posedge clk) disable iff (!nrst) fc_load[0] && !link_cfg[0][7]);
    COV_READ_TXN: cover property (@(posedge clk) disable iff (!nrst) txn_valid && !txn_write && match[0]);
    COV_BAD_PORT: cover property (@(posedge clk) disable iff (!nrst) reg_wr && !port_ok);
endmodule

/* sim/rpim_link_model.sv */
module rpim_link_model #(
    parameter int NPORTS = 2
) (
    // Clock.
    input wire logic clk,
    // Forward-channel words toward the block.
    output logic [NPORTS-1:0] fc_load,
    output logic [NPORTS*8-1:0] fc_link_cfg,
    output logic [NPORTS*7-1:0] fc_ser_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        fc_load = '0;
        fc_link_cfg = '0;
        fc_ser_addr = '0;
    end
    // Between words the data is inverted, so a stale word cannot pass for a fresh one.
    task automatic send(input int p, input logic [7:0] cfg, input logic [6:0] adr);
        @(posedge clk);
        #1;
        fc_link_cfg[p*8+:8] = cfg;
        fc_ser_addr[p*7+:7] = adr;
        fc_load[p] = 1'b1;
        @(posedge clk);
        #1;
        fc_load[p] = 1'b0;
        fc_link_cfg[p*8+:8] = ~cfg;
        fc_ser_addr[p*7+:7] = ~adr;
    endtask
endmodule

/* sim/tb_rpim_regs.sv */
module tb_rpim_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] fc_load;
    logic [15:0] fc_link_cfg;
    logic [13:0] fc_ser_addr;
    logic [1:0] pass_through_en = 2'h0;
    logic txn_valid = 1'b0;
    logic [6:0] txn_addr = 7'h00;
    logic txn_write = 1'b0;
    logic fwd_valid;
    logic [1:0] fwd_port;
    logic [6:0] fwd_addr;
    logic fwd_auto_ack;
    logic [5:0] gpio_enabled;
    int n_fail = 0;
    int check_count = 0;
    always #5 clk = ~clk;
    rpim_link_model #(.NPORTS(2)) u_rpim_link_model (.clk(clk), .fc_load(fc_load), .fc_link_cfg(fc_link_cfg),
        .fc_ser_addr(fc_ser_addr));
    rpim_regs #(.NPORTS(2)) u_rpim_regs (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fc_load(fc_load),
        .fc_link_cfg(fc_link_cfg), .fc_ser_addr(fc_ser_addr), .pass_through_en(pass_through_en),
        .txn_valid(txn_valid), .txn_addr(txn_addr), .txn_write(txn_write), .fwd_valid(fwd_valid),
        .fwd_port(fwd_port), .fwd_addr(fwd_addr), .fwd_auto_ack(fwd_auto_ack), .gpio_enabled(gpio_enabled));
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    // Sends one address phase and judges the registered forward outputs one cycle later.
    task automatic txn(input logic w, input logic [6:0] a, input logic [3:0] exp_v, input logic [6:0] exp_a);
        @(posedge clk);
        #1;
        txn_addr = a;
        txn_write = w;
        txn_valid = 1'b1;
        @(posedge clk);
        #1;
        txn_valid = 1'b0;
        chk("fwd_flags", {4'h0, fwd_valid, fwd_auto_ack, fwd_port}, {4'h0, exp_v});
        if (exp_v[3] === 1'b1) chk("fwd_addr", {1'b0, fwd_addr}, {1'b0, exp_a});
    endtask
    task automatic t_link();
        for (int i = 0; i < 5; i++) rd_chk(8'h59 + 8'(i), 8'h00);
        u_rpim_link_model.send(0, 8'h7e, 7'h15);
        rd_chk(8'h59, 8'h7e);
        rd_chk(8'h5b, 8'h2a);
        chk("gpio", {5'h0, gpio_enabled[2:0]}, 8'h02);
        wr(8'h59, 8'h01);
        rd_chk(8'h59, 8'h02);
        wr(8'h59, 8'h80);
        wr(8'h59, 8'h83);
        u_rpim_link_model.send(0, 8'h01, 7'h15);
        rd_chk(8'h59, 8'h83);
        chk("gpio", {5'h0, gpio_enabled[2:0]}, 8'h04);
        wr(8'h59, 8'h00);
        u_rpim_link_model.send(0, 8'h01, 7'h15);
        chk("gpio", {5'h0, gpio_enabled[2:0]}, 8'h01);
        wr(8'h5b, 8'h41);
        u_rpim_link_model.send(0, 8'h00, 7'h33);
        rd_chk(8'h5b, 8'h41);
        $display("t_link done");
    endtask
    task automatic t_ports();
        wr(8'h4c, 8'h01);
        wr(8'h5c, 8'h55);
        rd_chk(8'h5c, 8'h55);
        wr(8'h4c, 8'h04);
        wr(8'h5c, 8'h77);
        rd_chk(8'h5c, 8'h00);
        u_rpim_link_model.send(1, 8'h03, 7'h01);
        chk("gpio1", {5'h0, gpio_enabled[5:3]}, 8'h04);
        wr(8'h4c, 8'h00);
        rd_chk(8'h5c, 8'h00);
        rd_chk(8'h70, 8'h00);
        $display("t_ports done");
    endtask
    task automatic t_decode();
        wr(8'h5c, 8'h2b);
        wr(8'h5d, 8'hff);
        rd_chk(8'h5d, 8'hfe);
        pass_through_en = 2'h1;
        txn(1'b1, 7'h15, 4'hc, 7'h7f);
        txn(1'b0, 7'h15, 4'h8, 7'h7f);
        txn(1'b1, 7'h2a, 4'h2, 7'h00);
        wr(8'h4c, 8'h01);
        wr(8'h5c, 8'h00);
        pass_through_en = 2'h3;
        txn(1'b1, 7'h00, 4'h2, 7'h00);
        $display("t_decode done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The tests need well under a thousand cycles, so a hang is cut short early.
    initial begin
        #50000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1;
        nrst = 1'b1;
        t_link();
        t_ports();
        t_decode();
        summarize();
    end
endmodule
